// ===== core/mcs_sequencer.sv
// monitor cycle sequencer: channel stepping, value storage, limit checks,
// fan start and limit sense, analog output register, alert logic
// assumes the front end converts the selected channel and strobes a result
// back on this clock, and that fan_count arrives from logic on this clock
//
// Summary of operation
// RULE1: start bit one, clear zero begins cycle
// RULE2: software sets alert enable to drive alert
// RULE3: fixed order, core supply first, temperature last
// RULE4: each result lands in its value register
// RULE5: cycle repeats until start bit cleared
// RULE6: multiplexer stepped at 22.5 kHz, seven slots
// RULE7: fan monitoring starts with the analog cycle
// RULE8: voltage above high or below low alerts
// RULE9: overtemp set above hot, released at hysteresis
// RULE10: eight-bit output register, resets to all ones
// RULE11: only top eight temperature bits compared
// RULE12: fan count above limit raises fan failure
// RULE13: compare each time a value updates
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mcs_sequencer #(
   parameter int SLOT_CYCLES = mcs_pkg::SLOT_CYCLES, // clock cycles per slot
   parameter int NUM_CH = mcs_pkg::NUM_CH // channels per pass
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [2:0] mux_sel,
   output logic conv_start,
   input wire mcs_pkg::mcs_conv_t conv_in,
   output logic fan_start,
   input wire logic fan_valid,
   input wire logic [7:0] fan_count,
   output logic [7:0] dac_code,
   output logic alert_n,
   output logic irq
);
   // elaboration guard: the slot counter is sixteen bits wide and the status
   // layout assumes the seven-slot pass, so any other setting is refused here
   // rather than left to wrap silently
   if (NUM_CH != mcs_pkg::NUM_CH || SLOT_CYCLES < 2 || SLOT_CYCLES > 65536) begin : g_bad_param
      $error("mcs_sequencer: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and next values
   mcs_pkg::mcs_state_t state_reg, state_next; // idle or running
   logic [15:0] slot_cnt_reg, slot_cnt_next; // cycles into current slot
   logic [2:0] ch_reg, ch_next; // channel being converted
   logic conv_start_reg, conv_start_next; // start strobe to front end
   logic fan_start_reg, fan_start_next; // start strobe to fan counters
   logic [7:0] val_reg [NUM_CH]; // stored results
   logic [7:0] val_next [NUM_CH];
   logic [7:0] hi_reg [mcs_pkg::NUM_VOLT]; // voltage high limits
   logic [7:0] hi_next [mcs_pkg::NUM_VOLT];
   logic [7:0] lo_reg [mcs_pkg::NUM_VOLT]; // voltage low limits
   logic [7:0] lo_next [mcs_pkg::NUM_VOLT];
   logic temp_lsb_reg, temp_lsb_next; // ninth temperature bit, read back only
   logic [3:0] cfg_reg, cfg_next; // configuration bits
   logic [7:0] status_reg, status_next; // sticky events
   logic [7:0] mask_reg, mask_next; // interrupt mask
   logic [7:0] dac_reg, dac_next; // analog output code
   logic [7:0] fan_lim_reg, fan_lim_next;
   logic [7:0] hot_reg, hot_next;
   logic [7:0] hyst_reg, hyst_next;
   logic overtemp_reg, overtemp_next; // hysteretic overtemperature state
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next; // one wait state per access
   logic alert_n_reg, alert_n_next;
   logic irq_reg, irq_next;

   ////////////////////////////////////////////////////////////////////////////
   // bus helpers
   logic acc; // access taken this cycle
   logic wr; // write taken this cycle
   logic [7:0] wbyte; // low byte of write data, lane 0 only
   logic [7:0] ev; // events raised this cycle
   logic [2:0] widx; // word index inside a bank
   assign acc = (avs_read || avs_write) && wait_reg;
   // a write lands only at the edge where the master sees waitrequest low,
   // the same edge at which it drops the request; acting earlier would put
   // the register update one cycle ahead of the transfer itself
   assign wr = avs_write && !wait_reg && avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];
   assign widx = avs_address[4:2];

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic for the whole block
   always_comb begin
      logic run_go;
      logic [7:0] res;
      run_go = 1'b0;
      res = 8'h00;
      state_next = state_reg;
      slot_cnt_next = slot_cnt_reg;
      ch_next = ch_reg;
      conv_start_next = 1'b0;
      fan_start_next = 1'b0;
      val_next = val_reg;
      hi_next = hi_reg;
      lo_next = lo_reg;
      temp_lsb_next = temp_lsb_reg;
      cfg_next = cfg_reg;
      mask_next = mask_reg;
      dac_next = dac_reg;
      fan_lim_next = fan_lim_reg;
      hot_next = hot_reg;
      hyst_next = hyst_reg;
      overtemp_next = overtemp_reg;
      ev = 8'h00;
      rdata_next = rdata_reg;
      // every access sees exactly one wait state, then completes
      wait_next = !(acc);
      if (!(avs_read || avs_write)) begin
         wait_next = 1'b1;
      end
      // register writes
      if (wr) begin
         case (avs_address)
            mcs_pkg::OFS_CONFIG: cfg_next = wbyte[3:0];
            mcs_pkg::OFS_MASK: mask_next = wbyte;
            mcs_pkg::OFS_DAC: dac_next = wbyte; // RULE10
            mcs_pkg::OFS_FAN_LIM: fan_lim_next = wbyte;
            mcs_pkg::OFS_HOT: hot_next = wbyte;
            mcs_pkg::OFS_HYST: hyst_next = wbyte;
            default: begin
               if (avs_address[7:5] == mcs_pkg::OFS_HI[7:5] && widx < 3'd6) begin
                  hi_next[widx] = wbyte;
               end else if (avs_address[7:5] == mcs_pkg::OFS_LO[7:5] && widx < 3'd6) begin
                  lo_next[widx] = wbyte;
               end
            end
         endcase
      end
      // start only with clear bit low; the start is judged on the new value
      run_go = cfg_next[mcs_pkg::CFG_START] && !cfg_next[mcs_pkg::CFG_ALERT_CLR]; // RULE1
      case (state_reg)
         mcs_pkg::MCS_IDLE: begin
            if (run_go) begin
               state_next = mcs_pkg::MCS_RUN;
               ch_next = 3'd0; // RULE3
               slot_cnt_next = 16'h0000;
               conv_start_next = 1'b1;
               fan_start_next = 1'b1; // RULE7
            end
         end
         mcs_pkg::MCS_RUN: begin
            if (!run_go) begin
               state_next = mcs_pkg::MCS_IDLE; // RULE5
            end else if (slot_cnt_reg == 16'(SLOT_CYCLES - 1)) begin
               // the slot counter is the divider; its terminal count is the step enable
               // slot over: step the multiplexer and wrap after the last channel
               slot_cnt_next = 16'h0000; // RULE6
               ch_next = (ch_reg == 3'(NUM_CH - 1)) ? 3'd0 : ch_reg + 3'd1; // RULE3
               conv_start_next = 1'b1;
            end else begin
               slot_cnt_next = slot_cnt_reg + 16'h0001; // RULE6
            end
         end
         default: state_next = mcs_pkg::MCS_IDLE;
      endcase
      // result capture and immediate limit check on the stored channel
      if (conv_in.valid && state_reg == mcs_pkg::MCS_RUN) begin
         if (ch_reg == 3'(NUM_CH - 1)) begin
            res = conv_in.data[8:1]; // RULE11
            temp_lsb_next = conv_in.data[0];
            // signed compare of the top eight bits
            if ($signed(res) > $signed(hot_reg)) begin
               overtemp_next = 1'b1; // RULE9
            end else if ($signed(res) <= $signed(hyst_reg)) begin
               overtemp_next = 1'b0; // RULE9
            end
            if ($signed(res) > $signed(hot_reg)) begin
               ev[mcs_pkg::ST_TEMP] = 1'b1; // RULE13
            end
         end else begin
            res = conv_in.data[7:0];
            if (res > hi_reg[ch_reg] || res < lo_reg[ch_reg]) begin
               ev[ch_reg] = 1'b1; // RULE8 RULE13
            end
         end
         val_next[ch_reg] = res; // RULE4
      end
      // the fan logic keeps its own pace; only its start is shared with the pass
      // fan period above limit is an underspeed failure
      if (fan_valid && fan_count > fan_lim_reg) begin
         ev[mcs_pkg::ST_FAN] = 1'b1; // RULE12
      end
      // write one clears, a new event in the same cycle wins
      // a cleared bit comes back at the next result or fan count that still raises its event
      status_next = status_reg;
      if (wr && avs_address == mcs_pkg::OFS_STATUS) begin
         status_next = status_reg & ~wbyte;
      end
      if (cfg_next[mcs_pkg::CFG_ALERT_CLR]) begin
         status_next = 8'h00;
      end
      status_next = status_next | ev;
      // read data, captured at the wait-state cycle
      // reads have no side effect, so decoding them one cycle early is harmless
      if (avs_read && wait_reg) begin
         case (avs_address)
            mcs_pkg::OFS_CONFIG: rdata_next = {28'h0000000, cfg_reg};
            mcs_pkg::OFS_STATUS: rdata_next = {24'h000000, status_reg};
            mcs_pkg::OFS_MASK: rdata_next = {24'h000000, mask_reg};
            mcs_pkg::OFS_DAC: rdata_next = {24'h000000, dac_reg};
            mcs_pkg::OFS_FAN_LIM: rdata_next = {24'h000000, fan_lim_reg};
            mcs_pkg::OFS_HOT: rdata_next = {24'h000000, hot_reg};
            mcs_pkg::OFS_HYST: rdata_next = {24'h000000, hyst_reg};
            mcs_pkg::OFS_STATE: rdata_next = {26'h0000000, temp_lsb_reg, overtemp_reg,
               (state_reg == mcs_pkg::MCS_RUN), ch_reg};
            default: begin
               rdata_next = 32'h00000000; // unmapped reads as zero
               if (avs_address[7:5] == mcs_pkg::OFS_VAL[7:5] && widx < 3'(NUM_CH)) begin
                  rdata_next = {24'h000000, val_reg[widx]};
               end else if (avs_address[7:5] == mcs_pkg::OFS_HI[7:5] && widx < 3'd6) begin
                  rdata_next = {24'h000000, hi_reg[widx]};
               end else if (avs_address[7:5] == mcs_pkg::OFS_LO[7:5] && widx < 3'd6) begin
                  rdata_next = {24'h000000, lo_reg[widx]};
               end
            end
         endcase
      end
      // alert pin only driven low when enabled by software
      // irq follows the old mask, so a mask write shows one cycle later
      irq_next = |(status_next & mask_reg);
      alert_n_next = !(irq_next && cfg_next[mcs_pkg::CFG_ALERT_EN]); // RULE2
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   // only registering here; every next value comes from the block above
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= mcs_pkg::MCS_IDLE;
         slot_cnt_reg <= 16'h0000;
         ch_reg <= 3'd0;
         conv_start_reg <= 1'b0;
         fan_start_reg <= 1'b0;
         for (int i = 0; i < NUM_CH; i++) begin
            val_reg[i] <= 8'h00;
         end
         for (int i = 0; i < mcs_pkg::NUM_VOLT; i++) begin
            hi_reg[i] <= mcs_pkg::HI_RST;
            lo_reg[i] <= mcs_pkg::LO_RST;
         end
         temp_lsb_reg <= 1'b0;
         cfg_reg <= 4'h0;
         status_reg <= 8'h00;
         mask_reg <= 8'h00;
         dac_reg <= mcs_pkg::DAC_RST; // RULE10
         fan_lim_reg <= mcs_pkg::FAN_LIM_RST;
         hot_reg <= mcs_pkg::HOT_RST;
         hyst_reg <= mcs_pkg::HYST_RST;
         overtemp_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         wait_reg <= 1'b1;
         alert_n_reg <= 1'b1;
         irq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         slot_cnt_reg <= slot_cnt_next;
         ch_reg <= ch_next;
         conv_start_reg <= conv_start_next;
         fan_start_reg <= fan_start_next;
         val_reg <= val_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
         temp_lsb_reg <= temp_lsb_next;
         cfg_reg <= cfg_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         dac_reg <= dac_next;
         fan_lim_reg <= fan_lim_next;
         hot_reg <= hot_next;
         hyst_reg <= hyst_next;
         overtemp_reg <= overtemp_next;
         rdata_reg <= rdata_next;
         wait_reg <= wait_next;
         alert_n_reg <= alert_n_next;
         irq_reg <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign mux_sel = ch_reg;
   assign conv_start = conv_start_reg;
   assign fan_start = fan_start_reg;
   assign dac_code = dac_reg;
   assign alert_n = alert_n_reg;
   assign irq = irq_reg;
endmodule // mcs_sequencer
`default_nettype wire

// ===== core/mcs_pkg.sv
// package for the monitor cycle sequencer: register map, reset values, timing
// assumes a single 200 MHz clock and a 32-bit Avalon-MM slave with waitrequest
package mcs_pkg;
   // timing
   localparam int CLK_HZ = 200000000; // core clock rate
   localparam int SLOT_HZ = 22500; // nominal multiplexer stepping rate
   localparam int SLOT_CYCLES = CLK_HZ / SLOT_HZ; // cycles per channel slot
   localparam int NUM_CH = 7; // channels in one pass
   localparam int NUM_VOLT = 6; // voltage channels, temperature is the last
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00; // start, alert enable, alert clear
   localparam logic [7:0] OFS_STATUS = 8'h04; // sticky event bits, write one to clear
   localparam logic [7:0] OFS_MASK = 8'h08; // interrupt mask, one enables
   localparam logic [7:0] OFS_DAC = 8'h0c; // analog output code
   localparam logic [7:0] OFS_FAN_LIM = 8'h10; // fan period limit
   localparam logic [7:0] OFS_HOT = 8'h14; // hot limit
   localparam logic [7:0] OFS_HYST = 8'h18; // hysteresis limit
   localparam logic [7:0] OFS_STATE = 8'h1c; // channel index, running, overtemp
   localparam logic [7:0] OFS_VAL = 8'h20; // value registers, one word per channel
   localparam logic [7:0] OFS_HI = 8'h40; // voltage high limits
   localparam logic [7:0] OFS_LO = 8'h60; // voltage low limits
   // configuration field positions
   localparam int CFG_START = 0;
   localparam int CFG_ALERT_EN = 1;
   localparam int CFG_ALERT_CLR = 3;
   // status field positions: 0..5 voltage, 6 overtemp, 7 fan failure
   localparam int ST_TEMP = 6;
   localparam int ST_FAN = 7;
   // reset values
   localparam logic [7:0] DAC_RST = 8'hff; // full fan speed
   localparam logic [7:0] HI_RST = 8'hff;
   localparam logic [7:0] LO_RST = 8'h00;
   localparam logic [7:0] FAN_LIM_RST = 8'hff;
   localparam logic [7:0] HOT_RST = 8'h7f;
   localparam logic [7:0] HYST_RST = 8'h7f;
   // one conversion result handed in by the analog front end
   typedef struct packed {
      logic valid; // one-cycle strobe
      logic [8:0] data; // temperature uses nine bits, voltages the low eight
   } mcs_conv_t;
   // sequencer state
   typedef enum logic [0:0] {MCS_IDLE, MCS_RUN} mcs_state_t;
endpackage

// ===== tb/mcs_seq_chk.sv
// checker: slot stepping, bus answer, alert and output register relations
// assumes it is bound into mcs_sequencer and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module mcs_seq_chk #(
   parameter int SLOT_CYCLES = 4 // cycles per channel slot
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [2:0] mux_sel,
   input wire logic conv_start,
   input wire logic fan_start,
   input wire logic [7:0] dac_code,
   input wire logic alert_n,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   int slot_cnt; // cycles since the last slot start
   ////////////////////////////////////////////////////////////////////////
   // slot length counter, restarted by every slot start
   always_ff @(posedge core_clk) begin
      if (srst || conv_start) begin
         slot_cnt <= 0;
      end else begin
         slot_cnt <= slot_cnt + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   dac_rst_a: assert property ($past(srst) |-> dac_code == 8'hff)
      else $error("output code not full scale after reset");
   dac_hold_a: assert property (!$past(avs_write) |-> $stable(dac_code))
      else $error("output code moved without a write");
   fan_sync_a: assert property (fan_start |-> conv_start && mux_sel == 3'h0)
      else $error("fan start not aligned with first slot");
   fan_once_a: assert property (fan_start |=> !fan_start [*3])
      else $error("fan start repeated");
   step_next_a: assert property (conv_start && !fan_start |->
      mux_sel == (($past(mux_sel) == 3'h6) ? 3'h0 : $past(mux_sel) + 3'h1))
      else $error("channel order broken");
   slot_len_a: assert property (conv_start && !fan_start |-> slot_cnt == SLOT_CYCLES - 1)
      else $error("slot length wrong");
   alert_irq_a: assert property (!alert_n |-> irq)
      else $error("alert without pending masked event");
   wait_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest)
      else $error("bus answer late");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held too long");
   // main scenarios reached
   start_c: cover property (fan_start);
   wrap_c: cover property (conv_start && mux_sel == 3'h6);
   alert_c: cover property (!alert_n);
endmodule // mcs_seq_chk
bind mcs_sequencer mcs_seq_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_mcs_seq_chk (
   .core_clk(core_clk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .mux_sel(mux_sel), .conv_start(conv_start),
   .fan_start(fan_start), .dac_code(dac_code), .alert_n(alert_n), .irq(irq));
`default_nettype wire

// ===== tb/monitor_cycle_sequencer_tb.sv
// testbench: drives the register bus, front end results and fan counts
// assumes a short slot length so a pass takes few cycles
`timescale 1ns/1ps
`default_nettype none
module monitor_cycle_sequencer_tb;
   localparam int SC = 4; // shortened slot
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [2:0] mux_sel;
   logic conv_start;
   logic fan_start;
   logic fan_valid = 1'b0;
   logic [7:0] fan_count = 8'h00;
   logic [7:0] dac_code;
   logic alert_n;
   logic irq;
   mcs_pkg::mcs_conv_t conv_in = '0;
   logic wq; // waitrequest as it stands before the next edge
   logic [31:0] rq; // read data likewise
   logic cs_q; // slot start seen
   logic [2:0] ms_q; // channel of that slot
   logic [2:0] seq_log[$]; // channel at each slot start
   int fan_cnt = 0;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   logic [7:0] vals[6] = '{8'h81, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55}; // ch1 below its low limit
   logic [8:0] temp_data = 9'h083; // top bits 41, above hot
   logic [31:0] q;
   always #2.5 core_clk = ~core_clk;
   mcs_sequencer #(.SLOT_CYCLES(SC)) u_mcs_sequencer (.core_clk(core_clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mux_sel(mux_sel), .conv_start(conv_start),
      .conv_in(conv_in), .fan_start(fan_start), .fan_valid(fan_valid),
      .fan_count(fan_count), .dac_code(dac_code), .alert_n(alert_n), .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   // settled outputs are taken mid-cycle, so no edge race decides them
   always @(negedge core_clk) begin
      wq = avs_waitrequest;
      rq = avs_readdata;
      cs_q = conv_start;
      ms_q = mux_sel;
      if (conv_start === 1'b1) seq_log.push_back(mux_sel);
      if (fan_start === 1'b1) fan_cnt++;
   end
   // front end: one result per slot, the cycle after the slot starts
   always @(posedge core_clk) begin
      conv_in.valid <= cs_q;
      conv_in.data <= (ms_q == 3'h6) ? temp_data : {1'b0, vals[ms_q]};
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one Avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (wq !== 1'b0 && n < 20);
      q = rq;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk("bus answer", 32'h1, 32'(n < 20));
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      bus(1'b0, a, 8'h00);
      chk(nm, {24'h0, exp}, q);
   endtask
   task automatic fan(input logic [7:0] c);
      @(posedge core_clk);
      fan_valid <= 1'b1;
      fan_count <= c;
      @(posedge core_clk);
      fan_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      @(negedge core_clk);
      chk("dac after reset", 32'hff, 32'(dac_code));
      chk("irq after reset", 32'h0, 32'(irq));
      rd(mcs_pkg::OFS_HOT, 8'h7f, "hot limit");
      rd(mcs_pkg::OFS_HI, 8'hff, "high limit");
      rd(8'hfc, 8'h00, "unmapped");
   endtask
   task automatic t_start();
      bus(1'b1, mcs_pkg::OFS_HI, 8'h80);
      bus(1'b1, mcs_pkg::OFS_LO + 8'h04, 8'h20);
      bus(1'b1, mcs_pkg::OFS_MASK, 8'hff);
      bus(1'b1, mcs_pkg::OFS_HOT, 8'h40);
      bus(1'b1, mcs_pkg::OFS_HYST, 8'h30);
      bus(1'b1, mcs_pkg::OFS_FAN_LIM, 8'h80);
      bus(1'b1, mcs_pkg::OFS_CONFIG, 8'h09);
      repeat (10) @(posedge core_clk);
      chk("start with clear set", 32'h0, seq_log.size());
      bus(1'b1, mcs_pkg::OFS_CONFIG, 8'h03);
      repeat (60) @(posedge core_clk);
      chk("fan starts", 32'h1, fan_cnt);
      for (int i = 0; i < 14; i++) chk("channel order", i % 7, seq_log[i]);
   endtask
   task automatic t_limits();
      for (int c = 0; c < 6; c++) rd(mcs_pkg::OFS_VAL + 8'(4 * c), vals[c], "value");
      rd(mcs_pkg::OFS_VAL + 8'h18, 8'h41, "temperature value");
      rd(mcs_pkg::OFS_STATUS, 8'h43, "status");
      bus(1'b0, mcs_pkg::OFS_STATE, 8'h00);
      chk("running", 32'h1, 32'(q[3]));
      chk("temperature low bit", 32'h1, 32'(q[5]));
      @(negedge core_clk);
      chk("alert", 32'h0, 32'(alert_n));
      fan(8'h80);
      rd(mcs_pkg::OFS_STATUS, 8'h43, "fan at limit");
      fan(8'h81);
      rd(mcs_pkg::OFS_STATUS, 8'hc3, "fan over limit");
   endtask
   task automatic t_temp();
      temp_data = 9'h06a;
      repeat (40) @(posedge core_clk);
      bus(1'b0, mcs_pkg::OFS_STATE, 8'h00);
      chk("overtemp held", 32'h1, 32'(q[4]));
      temp_data = 9'h060;
      repeat (40) @(posedge core_clk);
      bus(1'b0, mcs_pkg::OFS_STATE, 8'h00);
      chk("overtemp released", 32'h0, 32'(q[4]));
      bus(1'b1, mcs_pkg::OFS_STATUS, 8'h40);
      rd(mcs_pkg::OFS_STATUS, 8'h83, "status after clear");
      bus(1'b1, mcs_pkg::OFS_MASK, 8'h00);
      repeat (2) @(negedge core_clk);
      chk("masked irq", 32'h0, 32'(irq));
      chk("masked alert", 32'h1, 32'(alert_n));
   endtask
   task automatic t_stop();
      int n;
      bus(1'b1, mcs_pkg::OFS_CONFIG, 8'h02);
      n = seq_log.size();
      repeat (40) @(posedge core_clk);
      chk("stopped", n, seq_log.size());
      bus(1'b0, mcs_pkg::OFS_STATE, 8'h00);
      chk("running after stop", 32'h0, 32'(q[3]));
      bus(1'b1, mcs_pkg::OFS_DAC, 8'h5a);
      @(negedge core_clk);
      chk("dac output", 32'h5a, 32'(dac_code));
      rd(mcs_pkg::OFS_DAC, 8'h5a, "dac register");
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      t_reset();
      t_start();
      t_limits();
      t_temp();
      t_stop();
      conclude();
   end
endmodule // monitor_cycle_sequencer_tb
`default_nettype wire
